// *** core/cgs_pkg.sv ***
/*
  Constants for the serial status and programming register bank of the
  clock generator: register offsets, field positions, reset values, the
  fixed identity codes, the slave address and the serial engine states.
  Assumes every user refers to these by cgs_pkg::name.
*/
// What this block does
// - The display divider reads back as nine bits: low eight in byte 9, ninth in byte 8 bit 7.
// - Status bits 7 and 6 show frequency selects B and C as captured after power-up.
// - Status bit 5 shows the live level of clock request input zero.
// - Status bit 4 shows the live level of clock request input one.
// - Status bit 3 shows the live level of clock request input two; bits 2 to 0 read zero.
// - Byte 11 is read-only and holds the revision code above the maker code.
// - Byte 12 is read-only and holds the part code in its upper nibble, zeros below.
// - Byte 15 holds a writable six-bit block read length that resets to 0xf.
// - Bytes 13 and 14 are reserved and read as zero.
// - Bytes 16 to 40 are reserved and have no function.
// - The processor divider accepts writes only while byte 41 bit 1 is set, reset clear.
// - The display divider accepts writes only while byte 41 bit 0 is set, reset clear.
// - Test mode is entered only when the test select pin is high at power-up.
// - Once entered, test mode is left only by a new power-up.
// - In test mode a low test mode pin floats all outputs, a high one gives reference over N.

package cgs_pkg;

  // Register offsets
  localparam logic [7:0] REG_CPU_DIV_HI  = 8'h04;
  localparam logic [7:0] REG_CPU_DIV_LO  = 8'h05;
  localparam logic [7:0] REG_DISP_DIV_HI = 8'h08;
  localparam logic [7:0] REG_DISP_DIV_LO = 8'h09;
  localparam logic [7:0] REG_PIN_STATUS  = 8'h0a;
  localparam logic [7:0] REG_REV_MAKER   = 8'h0b;
  localparam logic [7:0] REG_PART_CODE   = 8'h0c;
  localparam logic [7:0] REG_RSVD_A      = 8'h0d;
  localparam logic [7:0] REG_RSVD_B      = 8'h0e;
  localparam logic [7:0] REG_READ_LEN    = 8'h0f;
  localparam logic [7:0] REG_RSVD_FIRST  = 8'h10;
  localparam logic [7:0] REG_RSVD_LAST   = 8'h28;
  localparam logic [7:0] REG_DIV_UNLOCK  = 8'h29;

  // Field positions
  localparam int STS_SEL_B_BIT    = 7;
  localparam int STS_SEL_C_BIT    = 6;
  localparam int STS_REQ0_BIT     = 5;
  localparam int STS_REQ1_BIT     = 4;
  localparam int STS_REQ2_BIT     = 3;
  localparam int DISP_HI_BIT      = 7;
  localparam int CPU_HI_BIT       = 0;
  localparam int UNLOCK_CPU_BIT   = 1;
  localparam int UNLOCK_DISP_BIT  = 0;

  // Reset values
  localparam logic [5:0] READ_LEN_RST = 6'h0f;
  localparam logic [1:0] UNLOCK_RST   = 2'h0;
  localparam logic [8:0] CPU_DIV_RST  = 9'h064;
  localparam logic [8:0] DISP_DIV_RST = 9'h0c8;

  // Identity codes, values arbitrary
  localparam logic [3:0] REV_CODE   = 4'h2;
  localparam logic [3:0] MAKER_CODE = 4'h5;
  localparam logic [3:0] PART_CODE  = 4'h9;

  // Serial slave address, value arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h69;

  // Pin bundle order and synchroniser reset levels
  localparam int         PIN_W   = 9;
  localparam logic [8:0] PIN_RST = 9'h19c;

  // Cycles after reset release before straps are caught
  localparam logic [2:0] STRAP_WAIT_CYC = 3'h4;

  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100,
    ST_WAIT   = 3'b101
  } cgs_smb_state_t;

endpackage : cgs_pkg

// *** core/cgs_pin_sync.sv ***
/*
  Three-stage synchroniser for a bundle of pins with agreement filter.
  Assumes inputs are asynchronous to clk_i; output updates only when the
  second and third stages agree.
*/
`timescale 1ns/1ps

module cgs_pin_sync #(
  parameter int             W   = 9,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] differ = stage2 ^ stage3;
  wire  [W-1:0] next_q = (~differ & stage2) | (differ & q_o);

  // Shift chain; hold last agreed level on disagreement
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage1 <= RST;
      stage2 <= RST;
      stage3 <= RST;
      q_o    <= RST;
    end else begin
      stage1 <= d_i;
      stage2 <= stage1;
      stage3 <= stage2;
      q_o    <= next_q;
    end
  end

endmodule : cgs_pin_sync

// *** core/cgs_test_ctrl.sv ***
/*
  Test mode control: catches the test select strap once after reset,
  keeps test mode until the next reset, and follows the test mode pin.
  Assumes capture_i pulses once after reset with settled pin levels.
*/
`timescale 1ns/1ps

module cgs_test_ctrl (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // Strap capture and filtered pins
  input  wire logic capture_i,
  input  wire logic test_select_i,
  input  wire logic test_mode_i,
  // Output control
  output logic      test_active_o,
  output logic      out_hiz_o,
  output logic      out_ref_div_o
);

  // Only a set path exists; nothing but reset clears it
  wire next_active = test_active_o | (capture_i & test_select_i);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      test_active_o <= 1'b0;
      out_hiz_o     <= 1'b0;
      out_ref_div_o <= 1'b0;
    end else begin
      test_active_o <= next_active;
      out_hiz_o     <= next_active & ~test_mode_i;
      out_ref_div_o <= next_active & test_mode_i;
    end
  end

endmodule : cgs_test_ctrl

// *** core/cgs_status_regs.sv ***
/*
  Serial register bank of the clock generator: a bit-level serial slave
  on the clock and data pins, the divider, status, identity, length and
  unlock registers, strap capture and test mode outputs.
  Assumes the data pin is open drain with an external pull-up and that
  the serial clock is far slower than sys_clk_i.
*/
`timescale 1ns/1ps

module cgs_status_regs (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Strap and status pins
  input  wire logic       freq_select_b_i,
  input  wire logic       freq_select_c_i,
  input  wire logic       clock_request_zero_n_i,
  input  wire logic       clock_request_one_n_i,
  input  wire logic       clock_request_two_n_i,
  // Test pins
  input  wire logic       test_select_i,
  input  wire logic       test_mode_i,
  // Programmed dividers
  output logic [8:0]      cpu_div_o,
  output logic [8:0]      display_div_o,
  // Latched straps and output control
  output logic            freq_select_b_latched_o,
  output logic            freq_select_c_latched_o,
  output logic            out_hiz_o,
  output logic            out_ref_div_o
);

  // Filtered pins
  logic [8:0] pins_f;
  wire        scl_f    = pins_f[8];
  wire        sda_f    = pins_f[7];
  wire        sel_b_f  = pins_f[6];
  wire        sel_c_f  = pins_f[5];
  wire        req0_n_f = pins_f[4];
  wire        req1_n_f = pins_f[3];
  wire        req2_n_f = pins_f[2];
  wire        tsel_f   = pins_f[1];
  wire        tmod_f   = pins_f[0];

  cgs_pin_sync #(
    .W   (cgs_pkg::PIN_W),
    .RST (cgs_pkg::PIN_RST)
  ) u_cgs_pin_sync (
    .clk_i    (sys_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({scl_i, sda_i, freq_select_b_i, freq_select_c_i,
                clock_request_zero_n_i, clock_request_one_n_i,
                clock_request_two_n_i, test_select_i, test_mode_i}),
    .q_o      (pins_f)
  );

  // Strap capture after settling
  logic [2:0] strap_cnt;
  logic       strap_done;
  logic       capture;
  wire        strap_hit = (strap_cnt == cgs_pkg::STRAP_WAIT_CYC) & ~strap_done;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_cnt  <= 3'h0;
      strap_done <= 1'b0;
      capture    <= 1'b0;
    end else begin
      strap_cnt  <= strap_done ? strap_cnt : strap_cnt + 3'h1;
      strap_done <= strap_done | strap_hit;
      capture    <= strap_hit;
    end
  end

  // Frequency selects frozen at capture
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      freq_select_b_latched_o <= 1'b0;
      freq_select_c_latched_o <= 1'b0;
    end else if (capture) begin
      freq_select_b_latched_o <= sel_b_f;
      freq_select_c_latched_o <= sel_c_f;
    end
  end

  // Test mode control
  logic test_active;

  cgs_test_ctrl u_cgs_test_ctrl (
    .sys_clk_i     (sys_clk_i),
    .arst_n_i      (arst_n_i),
    .capture_i     (capture),
    .test_select_i (tsel_f),
    .test_mode_i   (tmod_f),
    .test_active_o (test_active),
    .out_hiz_o     (out_hiz_o),
    .out_ref_div_o (out_ref_div_o)
  );

  // Serial bus edges and conditions
  logic scl_d;
  logic sda_d;
  wire  scl_rise  = scl_f & ~scl_d;
  wire  scl_fall  = ~scl_f & scl_d;
  wire  start_det = scl_f & scl_d & sda_d & ~sda_f;
  wire  stop_det  = scl_f & scl_d & ~sda_d & sda_f;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Serial engine state
  cgs_pkg::cgs_smb_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] byte_idx;
  logic       rd_mode;
  logic [7:0] ptr;
  logic [5:0] tx_left;
  logic [7:0] tx_byte;
  logic       master_nack;

  // Register contents
  logic [5:0] read_len;
  logic [1:0] unlock;

  // Read decode of one byte offset
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [8:0] cdiv,
                                          input logic [8:0] ddiv, input logic [7:0] sts,
                                          input logic [5:0] len, input logic [1:0] unl);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      cgs_pkg::REG_CPU_DIV_HI:  r = {7'h00, cdiv[8]};
      cgs_pkg::REG_CPU_DIV_LO:  r = cdiv[7:0];
      cgs_pkg::REG_DISP_DIV_HI: r = {ddiv[8], 7'h00};
      cgs_pkg::REG_DISP_DIV_LO: r = ddiv[7:0];
      cgs_pkg::REG_PIN_STATUS:  r = sts;
      cgs_pkg::REG_REV_MAKER:   r = {cgs_pkg::REV_CODE, cgs_pkg::MAKER_CODE};
      cgs_pkg::REG_PART_CODE:   r = {cgs_pkg::PART_CODE, 4'h0};
      cgs_pkg::REG_READ_LEN:    r = {2'h0, len};
      cgs_pkg::REG_DIV_UNLOCK:  r = {6'h00, unl};
      default:                  r = 8'h00;
    endcase
    return r;
  endfunction : reg_read

  // Status byte: latched selects, live request pins, reserved zeros
  wire [7:0] status_byte = {freq_select_b_latched_o, freq_select_c_latched_o,
                            req0_n_f,
                            req1_n_f,
                            req2_n_f,
                            3'h0};
  wire [7:0] rd_data = reg_read(ptr, cpu_div_o, display_div_o, status_byte, read_len, unlock);
  wire [7:0] ptr_rd_idx = ptr;
  wire [7:0] next_shreg = {shreg[6:0], sda_f};
  wire       byte_end   = (state == cgs_pkg::ST_RX) & scl_fall & (bit_cnt == 4'h8);
  wire       addr_hit   = (shreg[7:1] == cgs_pkg::SLAVE_ADDR);
  wire [1:0] next_idx   = (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;

  // Write strobe for a data byte; every data byte is acknowledged
  wire wr_en       = byte_end & (byte_idx == 2'h3) & ~rd_mode;
  wire wr_len      = wr_en & (ptr == cgs_pkg::REG_READ_LEN);
  wire wr_unlock   = wr_en & (ptr == cgs_pkg::REG_DIV_UNLOCK);
  wire wr_cpu_hi   = wr_en & (ptr == cgs_pkg::REG_CPU_DIV_HI) & unlock[cgs_pkg::UNLOCK_CPU_BIT];
  wire wr_cpu_lo   = wr_en & (ptr == cgs_pkg::REG_CPU_DIV_LO) & unlock[cgs_pkg::UNLOCK_CPU_BIT];
  wire wr_disp_hi  = wr_en & (ptr == cgs_pkg::REG_DISP_DIV_HI) & unlock[cgs_pkg::UNLOCK_DISP_BIT];
  wire wr_disp_lo  = wr_en & (ptr == cgs_pkg::REG_DISP_DIV_LO) & unlock[cgs_pkg::UNLOCK_DISP_BIT];

  // Writable registers; all other offsets drop the data
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_len      <= cgs_pkg::READ_LEN_RST;
      unlock        <= cgs_pkg::UNLOCK_RST;
      cpu_div_o     <= cgs_pkg::CPU_DIV_RST;
      display_div_o <= cgs_pkg::DISP_DIV_RST;
    end else begin
      if (wr_len) read_len <= shreg[5:0];
      if (wr_unlock) unlock <= shreg[1:0];
      if (wr_cpu_hi) cpu_div_o[8] <= shreg[cgs_pkg::CPU_HI_BIT];
      if (wr_cpu_lo) cpu_div_o[7:0] <= shreg;
      if (wr_disp_hi) display_div_o[8] <= shreg[cgs_pkg::DISP_HI_BIT];
      if (wr_disp_lo) display_div_o[7:0] <= shreg;
    end
  end

  // Serial engine: bits in on rising clock, out and ack on falling clock
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state       <= cgs_pkg::ST_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      byte_idx    <= 2'h0;
      rd_mode     <= 1'b0;
      ptr         <= 8'h00;
      tx_left     <= 6'h00;
      tx_byte     <= 8'h00;
      master_nack <= 1'b0;
      sda_oe_o    <= 1'b0;
    end else if (stop_det) begin
      state    <= cgs_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state    <= cgs_pkg::ST_RX;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'h0;
      rd_mode  <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        cgs_pkg::ST_RX: begin
          if (scl_rise && bit_cnt != 4'h8) begin
            shreg   <= next_shreg;
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            if (byte_idx == 2'h0 && !addr_hit) begin
              state <= cgs_pkg::ST_WAIT;
            end else begin
              sda_oe_o <= 1'b1;
              state    <= cgs_pkg::ST_RX_ACK;
              byte_idx <= next_idx;
              if (byte_idx == 2'h0) rd_mode <= shreg[0];
              if (byte_idx == 2'h1) ptr <= shreg;
              if (byte_idx == 2'h3) ptr <= ptr + 8'h01;
            end
          end
        end
        cgs_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              tx_byte  <= {2'h0, read_len};
              tx_left  <= read_len;
              sda_oe_o <= 1'b1;
              state    <= cgs_pkg::ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state    <= cgs_pkg::ST_RX;
            end
          end
        end
        cgs_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              sda_oe_o <= 1'b0;
              state    <= cgs_pkg::ST_TX_ACK;
            end else begin
              sda_oe_o <= ~tx_byte[6];
              tx_byte  <= {tx_byte[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 4'h1;
            end
          end
        end
        cgs_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            master_nack <= sda_f;
          end else if (scl_fall) begin
            if (master_nack || tx_left == 6'h00) begin
              state <= cgs_pkg::ST_WAIT;
            end else begin
              tx_byte  <= rd_data;
              sda_oe_o <= ~rd_data[7];
              ptr      <= ptr + 8'h01;
              tx_left  <= tx_left - 6'h01;
              bit_cnt  <= 4'h0;
              state    <= cgs_pkg::ST_TX;
            end
          end
        end
        cgs_pkg::ST_IDLE, cgs_pkg::ST_WAIT: begin
          sda_oe_o <= 1'b0;
        end
        default: begin
          state    <= cgs_pkg::ST_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_disp_div_lock: assert property (
    $changed(display_div_o) |-> $past(unlock[cgs_pkg::UNLOCK_DISP_BIT]) && $past(wr_en))
    else $error("display divider changed while locked");

  a_cpu_div_lock: assert property (
    $changed(cpu_div_o) |-> $past(unlock[cgs_pkg::UNLOCK_CPU_BIT]) && $past(wr_en))
    else $error("cpu divider changed while locked");

  a_disp_div_view: assert property (
    (ptr_rd_idx == cgs_pkg::REG_DISP_DIV_LO) |-> rd_data == display_div_o[7:0])
    else $error("display divider low byte misread");

  a_strap_frozen: assert property (
    strap_done && !capture |=> $stable(freq_select_b_latched_o)
                               && $stable(freq_select_c_latched_o))
    else $error("frequency select changed after capture");

  a_status_req0: assert property (
    (ptr_rd_idx == cgs_pkg::REG_PIN_STATUS) |-> rd_data[cgs_pkg::STS_REQ0_BIT] == req0_n_f)
    else $error("request zero readback wrong");

  a_status_req1: assert property (
    (ptr_rd_idx == cgs_pkg::REG_PIN_STATUS) |-> rd_data[cgs_pkg::STS_REQ1_BIT] == req1_n_f)
    else $error("request one readback wrong");

  a_status_req2: assert property (
    (ptr_rd_idx == cgs_pkg::REG_PIN_STATUS) |->
      rd_data[cgs_pkg::STS_REQ2_BIT] == req2_n_f && rd_data[2:0] == 3'h0)
    else $error("request two readback or reserved bits wrong");

  a_ident_bytes: assert property (
    (ptr_rd_idx == cgs_pkg::REG_REV_MAKER) |-> rd_data == 8'h25)
    else $error("revision and maker byte wrong");

  a_part_byte: assert property (
    (ptr_rd_idx == cgs_pkg::REG_PART_CODE) |-> rd_data == 8'h90)
    else $error("part code byte wrong");

  a_read_len_write: assert property (
    $changed(read_len) |-> $past(wr_len) && read_len == $past(shreg[5:0]))
    else $error("read length changed without a write");

  a_rsvd_zero: assert property (
    (ptr_rd_idx >= cgs_pkg::REG_RSVD_A && ptr_rd_idx <= cgs_pkg::REG_RSVD_B) ||
    (ptr_rd_idx >= cgs_pkg::REG_RSVD_FIRST && ptr_rd_idx <= cgs_pkg::REG_RSVD_LAST)
      |-> rd_data == 8'h00)
    else $error("reserved byte not zero");

  a_test_entry: assert property (
    capture && !tsel_f |=> !test_active)
    else $error("test mode entered without strap");

  a_test_sticky: assert property (
    test_active |=> test_active [*2])
    else $error("test mode left without reset");

  a_test_outputs: assert property (
    test_active |=> out_ref_div_o == $past(tmod_f) && out_hiz_o == !$past(tmod_f))
    else $error("test output mode does not follow pin");

  a_ack_any_write: assert property (
    wr_en |=> sda_oe_o && state == cgs_pkg::ST_RX_ACK)
    else $error("data byte not acknowledged");

endmodule : cgs_status_regs

// *** test/cgs_host_model.sv ***
/*
  Serial bus host model: drives the clock line and pulls the data line low.
  Assumes a pull-up on the data line outside and clk_i at 250 MHz.
*/
`timescale 1ns/1ps

module cgs_host_model #(
  parameter int Q = 8
) (
  // Clock
  input  wire logic clk_i,
  // Serial bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // Idle bus at time zero
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Wait n falling edges
  task automatic hw(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hw

  // Start, also used as repeated start
  task automatic start();
    sda_pull_o = 1'b0;
    hw(Q);
    scl_o = 1'b1;
    hw(Q);
    sda_pull_o = 1'b1;
    hw(Q);
    scl_o = 1'b0;
    hw(Q);
  endtask : start

  // Stop: data rises while clock high
  task automatic stop();
    sda_pull_o = 1'b1;
    hw(Q);
    scl_o = 1'b1;
    hw(Q);
    sda_pull_o = 1'b0;
    hw(Q);
  endtask : stop

  // Eight bits MSB first plus the acknowledge slot; a one releases the line
  task automatic xfer(input logic [7:0] tx, input logic a9,
                      output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, a9};
    for (int i = 8; i >= 0; i--) begin
      sda_pull_o = ~sh[i];
      hw(Q);
      scl_o = 1'b1;
      hw(Q);
      sh[i] = sda_i;
      hw(Q);
      scl_o = 1'b0;
      hw(Q);
    end
    rx  = sh[8:1];
    ack = ~sh[0];
  endtask : xfer
endmodule : cgs_host_model

// *** test/cgs_status_regs_tb_top.sv ***
/*
  Testbench for the serial register bank: reads, writes, pins, test mode.
  Assumes the host model in cgs_host_model and the design's assertions.
*/
`timescale 1ns/1ps

module cgs_status_regs_tb_top;
  // Clock, reset and pins
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl, pull, sda_o, sda_oe, sel_b = 1'b1, sel_c = 1'b0;
  logic [2:0] cr = 3'h7;
  logic       tsel = 1'b0, tmode = 1'b0;
  logic [8:0] cpu_div, disp_div;
  logic       sel_b_l, sel_c_l, hiz, refdiv;
  wire        sda;
  int         miscompares = 0;
  int         num_checks = 0;

  // Open-drain data line with pull-up
  assign sda = ~(pull | (sda_oe & ~sda_o));

  initial begin
    forever #2 clk = ~clk;
  end

  cgs_status_regs u_cgs_status_regs (
    .sys_clk_i(clk), .arst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .freq_select_b_i(sel_b),
    .freq_select_c_i(sel_c), .clock_request_zero_n_i(cr[2]),
    .clock_request_one_n_i(cr[1]), .clock_request_two_n_i(cr[0]),
    .test_select_i(tsel), .test_mode_i(tmode), .cpu_div_o(cpu_div),
    .display_div_o(disp_div), .freq_select_b_latched_o(sel_b_l),
    .freq_select_c_latched_o(sel_c_l), .out_hiz_o(hiz), .out_ref_div_o(refdiv)
  );

  cgs_host_model u_cgs_host_model (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull)
  );

  // Compare and count
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Power-up with given straps
  task automatic por(input logic ts, input logic b, input logic c);
    @(negedge clk);
    {tsel, sel_b, sel_c} = {ts, b, c};
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
  endtask : por

  // Single byte write; every byte must be acknowledged
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] rx;
    logic [3:0] a;
    u_cgs_host_model.start();
    u_cgs_host_model.xfer({cgs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, rx, a[3]);
    u_cgs_host_model.xfer(off, 1'b1, rx, a[2]);
    u_cgs_host_model.xfer(8'h01, 1'b1, rx, a[1]);
    u_cgs_host_model.xfer(d, 1'b1, rx, a[0]);
    u_cgs_host_model.stop();
    check(a, 4'hf);
  endtask : wr

  // Block read of nb data bytes; returns count byte and last byte
  task automatic rd(input logic [7:0] off, input int nb,
                    output logic [7:0] cnt, output logic [7:0] last);
    logic a;
    u_cgs_host_model.start();
    u_cgs_host_model.xfer({cgs_pkg::SLAVE_ADDR, 1'b0}, 1'b1, last, a);
    u_cgs_host_model.xfer(off, 1'b1, last, a);
    u_cgs_host_model.start();
    u_cgs_host_model.xfer({cgs_pkg::SLAVE_ADDR, 1'b1}, 1'b1, last, a);
    u_cgs_host_model.xfer(8'hff, 1'b0, cnt, a);
    for (int k = 0; k < nb; k++) begin
      u_cgs_host_model.xfer(8'hff, k == nb - 1, last, a);
    end
    u_cgs_host_model.stop();
  endtask : rd

  // Read one byte and compare
  task automatic rchk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] c, d;
    rd(off, 1, c, d);
    check(d, exp);
  endtask : rchk

  // Fixed and reserved bytes, reset values
  task automatic t_ids();
    rchk(8'h0b, {cgs_pkg::REV_CODE, cgs_pkg::MAKER_CODE});
    rchk(8'h0c, {cgs_pkg::PART_CODE, 4'h0});
    rchk(8'h0d, 8'h00);
    rchk(8'h0e, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h28, 8'h00);
    rchk(8'h0f, 8'h0f);
    rchk(8'h29, 8'h00);
    rchk(8'h09, cgs_pkg::DISP_DIV_RST[7:0]);
    rchk(8'h08, {cgs_pkg::DISP_DIV_RST[8], 7'h00});
    $display("test ids done");
  endtask : t_ids

  // Writes to fixed, reserved and locked bytes are dropped
  task automatic t_ro();
    logic [7:0] offs [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h0a, 8'h09, 8'h08};
    foreach (offs[i]) wr(offs[i], 8'hff);
    check(disp_div, cgs_pkg::DISP_DIV_RST);
    rchk(8'h0b, {cgs_pkg::REV_CODE, cgs_pkg::MAKER_CODE});
    rchk(8'h0d, 8'h00);
    $display("test read-only done");
  endtask : t_ro

  // Unlock bits gate each divider separately
  task automatic t_unlock();
    wr(8'h29, 8'hff);
    rchk(8'h29, 8'h03);
    wr(8'h09, 8'hab);
    wr(8'h08, 8'h80);
    wr(8'h05, 8'h5a);
    wr(8'h04, 8'h01);
    check(disp_div, 9'h1ab);
    check(cpu_div, 9'h15a);
    rchk(8'h09, 8'hab);
    wr(8'h29, 8'h01);
    wr(8'h05, 8'h33);
    check(cpu_div, 9'h15a);
    wr(8'h29, 8'h00);
    wr(8'h09, 8'h00);
    check(disp_div, 9'h1ab);
    $display("test unlock done");
  endtask : t_unlock

  // Length byte: six bits kept, block read stops when exhausted
  task automatic t_length();
    logic [7:0] c, d;
    wr(8'h0f, 8'hff);
    rchk(8'h0f, 8'h3f);
    wr(8'h0f, 8'h02);
    rd(8'h0b, 3, c, d);
    check(c, 8'h02);
    check(d, 8'hff);
    rd(8'h0b, 2, c, d);
    check(d, {cgs_pkg::PART_CODE, 4'h0});
    wr(8'h0f, 8'h0f);
    $display("test length done");
  endtask : t_length

  // Live request pins beside latched straps
  task automatic t_pins();
    @(negedge clk);
    {sel_b, sel_c} = 2'b01;
    for (int i = 0; i < 4; i++) begin
      cr = 3'h1 << i;
      repeat (10) @(negedge clk);
      rchk(8'h0a, {2'b10, cr, 3'b000});
    end
    check({sel_b_l, sel_c_l}, 2'b10);
    $display("test pins done");
  endtask : t_pins

  // Test mode entry, outputs, and stickiness
  task automatic t_test();
    tmode = 1'b1;
    tsel  = 1'b1;
    repeat (10) @(negedge clk);
    check({hiz, refdiv}, 2'b00);
    por(1'b1, 1'b0, 1'b1);
    tmode = 1'b0;
    repeat (10) @(negedge clk);
    check({hiz, refdiv}, 2'b10);
    tmode = 1'b1;
    tsel  = 1'b0;
    wr(8'h29, 8'h03);
    check({hiz, refdiv}, 2'b01);
    check({sel_b_l, sel_c_l}, 2'b01);
    por(1'b0, 1'b1, 1'b0);
    check({hiz, refdiv}, 2'b00);
    $display("test mode done");
  endtask : t_test

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    por(1'b0, 1'b1, 1'b0);
    t_ids();
    t_ro();
    t_unlock();
    t_length();
    t_pins();
    t_test();
    finish_test();
  end

  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule : cgs_status_regs_tb_top
